// file: rtl/bcdec_top.sv
// boot configuration decoder: reset-cause sequencer, option decode, axi4-lite regs
// Functional notes
// R1: por or brownout: clkdiv, flash, trim, full ram
// R2: external reset: clkdiv, flash, trim, stack clear
// R3: secure copy, sim or debugger reset: stack clear
// R4: debugger attached selects emulation configuration
// R5: clock, trace, logic nmi: log, clear, continue
// R6: ram or rom error: full ram init, reset
// R7: flash error resets, logged; selftest nmi unlogged
// R8: illegal instruction stores address, then reset
// R9: unsupported interrupts ignored, boot continues
// R10: wiped status shown by nmi watchdog cause
// R11: zone 2 configuration overrides zone 1
// R12: emulation words rewritable, zone words write once
// R13: options word used only with key 0x5a
// R14: bits 7:6 choose memory selftest mode
// R15: pll selftest skipped when pll unlocked
// R16: bits 5:4 pick error pin, locked
// R17: bits 3:0 feed scan node identifier
// R18: flash codes map to six entry points
// R19: ram code 0x05 enters at zero
// R20: secure flash codes map to five entries
// R21: wait mode loops, halt point for debugger
// R22: program pin and options words together; each zone word is written and locked by its own write
// R23: unsupported mode: wait if debugger, else flash
// R24: unrecognised mode with debugger enters wait
// R25: entry address and done strobe after init
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module bcdec_top #(
  parameter int IDX_W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic por_reset,
  input wire logic brownout_reset,
  input wire logic external_pin_reset,
  input wire logic nmi_watchdog_reset,
  input wire logic secure_copy_reset,
  input wire logic simulated_cpu_reset,
  input wire logic debugger_reset,
  input wire logic debugger_attached,
  input wire logic [IDX_W-1:0] boot_pin_index,
  input wire logic pll_locked,
  input wire logic ram_erased,
  input wire logic clock_fail,
  input wire logic trace_analysis_nmi,
  input wire logic config_logic_nmi,
  input wire logic ram_uncorrectable,
  input wire logic rom_parity_error,
  input wire logic flash_uncorrectable,
  input wire logic selftest_nmi,
  input wire logic illegal_instruction_trap,
  input wire logic [31:0] trap_address,
  input wire logic unsupported_irq,
  output logic clk_div_cfg,
  output logic flash_power_up,
  output logic trim_apply,
  output logic ram_init_all,
  output logic stack_clear,
  output logic nmi_flag_clear,
  output logic device_reset_req,
  output logic memory_selftest_start,
  output logic [1:0] memory_selftest_mode,
  output logic [1:0] error_status_output_sel,
  output logic [3:0] error_status_mux,
  output logic error_status_locked,
  output logic [3:0] scan_node_identifier,
  output logic [31:0] entry_address,
  output logic boot_done,
  output logic wait_loop,
  output logic debug_halt_point
);
  // the table holds eight bytes, so at most three select pins
  if (IDX_W < 1 || IDX_W > 3) begin : g_chk
    $error("IDX_W must lie between 1 and 3");
  end

  typedef struct packed {
    bcdec_pkg::bcdec_st_t st;
    logic full;
    logic ext;
    logic dbg;
    logic [IDX_W-1:0] idx;
    logic [3:0][31:0] emu;
    logic [3:0][31:0] z1;
    logic [3:0][31:0] z2;
    logic [3:0] prog1;
    logic [3:0] prog2;
    logic [bcdec_pkg::LOG_W-1:0] log;
    logic [31:0] trap;
    logic [31:0] entry;
    logic mp_run;
    logic [1:0] mp_mode;
    logic [1:0] errpin;
    logic [3:0] node;
    logic nmi_clr;
    logic wiped;
    logic aw_ok;
    logic [19:0] aw_idx;
    logic w_ok;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } bcdec_state_t;

  bcdec_state_t q, d;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] bcdec_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // table byte to {supported, wait, entry address}
  function automatic logic [33:0] bcdec_entry(input logic [7:0] b);
    logic [3:0] o;
    logic [33:0] r;
    o = b[7:4];
    r = '0;
    case (b[3:0])
      bcdec_pkg::MODE_FLASH:
        if (!o[0] && int'(o[3:1]) < bcdec_pkg::FLASH_OPTS)
          r = {2'b10, bcdec_pkg::FLASH_ENTRY[o[3:1]]}; // R18
      bcdec_pkg::MODE_SECURE:
        if (!o[0] && int'(o[3:1]) < bcdec_pkg::SECURE_OPTS)
          r = {2'b10, bcdec_pkg::FLASH_ENTRY[o[3:1]]}; // R20
      bcdec_pkg::MODE_RAM:
        if (o == 4'h0)
          r = {2'b10, bcdec_pkg::RAM_ENTRY}; // R19
      bcdec_pkg::MODE_WAIT:
        if (o == 4'h0 || o == 4'h2)
          r = {2'b11, 32'h0000_0000};
      default:
        r = '0;
    endcase
    return r;
  endfunction

  // selected configuration set and the decoded boot byte
  logic [31:0] cfg_pin, cfg_opt;
  logic [63:0] cfg_tbl;
  logic opt_key_ok, pin_key_ok, emu_key_bad, active, mp_pll, mp_skip;
  logic [7:0] boot_byte;
  logic [33:0] ent;
  logic [bcdec_pkg::LOG_W-1:0] log_set;
  always_comb
  begin
    if (q.dbg)
    begin
      cfg_pin = q.emu[0]; // R4
      cfg_opt = q.emu[1];
      cfg_tbl = {q.emu[3], q.emu[2]};
    end
    else if (q.z2[0][31:bcdec_pkg::KEY_LSB] == bcdec_pkg::KEY_VALID)
    begin
      cfg_pin = q.z2[0]; // R11
      cfg_opt = q.z2[1];
      cfg_tbl = {q.z2[3], q.z2[2]};
    end
    else
    begin
      cfg_pin = q.z1[0];
      cfg_opt = q.z1[1];
      cfg_tbl = {q.z1[3], q.z1[2]};
    end
    pin_key_ok = cfg_pin[31:bcdec_pkg::KEY_LSB] == bcdec_pkg::KEY_VALID;
    emu_key_bad = q.dbg && !pin_key_ok &&
                  cfg_pin[31:bcdec_pkg::KEY_LSB] != bcdec_pkg::KEY_ALT;
    opt_key_ok = cfg_opt[31:bcdec_pkg::KEY_LSB] == bcdec_pkg::KEY_VALID; // R13
    boot_byte = pin_key_ok ? cfg_tbl[8*q.idx +: 8] : bcdec_pkg::FACTORY_BYTE;
    ent = bcdec_entry(boot_byte);
    active = q.st inside {bcdec_pkg::ST_CLKDIV, bcdec_pkg::ST_FLASHUP,
                          bcdec_pkg::ST_TRIM, bcdec_pkg::ST_RAMALL,
                          bcdec_pkg::ST_STACK, bcdec_pkg::ST_DECODE,
                          bcdec_pkg::ST_MST};
    mp_pll = q.mp_mode != bcdec_pkg::MST_OSC;
    mp_skip = mp_pll && !pll_locked; // R15
  end

  // boot events that enter the log; unsupported interrupts never do
  always_comb
  begin
    log_set = '0; // R9
    if (active)
    begin
      log_set[bcdec_pkg::LOG_CLK] = clock_fail; // R5
      log_set[bcdec_pkg::LOG_TRACE] = trace_analysis_nmi;
      log_set[bcdec_pkg::LOG_CFGL] = config_logic_nmi;
      log_set[bcdec_pkg::LOG_RAM] = ram_uncorrectable; // R6
      log_set[bcdec_pkg::LOG_ROM] = rom_parity_error;
      log_set[bcdec_pkg::LOG_FLASH] = flash_uncorrectable; // R7
      log_set[bcdec_pkg::LOG_TRAP] = illegal_instruction_trap; // R8
    end
  end

  // next state: sequencer, exception handling and register slave
  always_comb
  begin
    d = q;
    d.nmi_clr = 1'b0;
    d.log = q.log | log_set;
    case (q.st)
      bcdec_pkg::ST_IDLE:
      begin
        d.full = por_reset | brownout_reset;
        d.ext = external_pin_reset | nmi_watchdog_reset;
        d.dbg = debugger_attached;
        d.idx = boot_pin_index;
        d.wiped = nmi_watchdog_reset & ram_erased; // R10
        d.st = (d.full | d.ext) ? bcdec_pkg::ST_CLKDIV : bcdec_pkg::ST_STACK; // R3
      end
      bcdec_pkg::ST_CLKDIV: d.st = bcdec_pkg::ST_FLASHUP; // R1 R2
      bcdec_pkg::ST_FLASHUP: d.st = bcdec_pkg::ST_TRIM;
      bcdec_pkg::ST_TRIM:
        d.st = q.full ? bcdec_pkg::ST_RAMALL : bcdec_pkg::ST_STACK; // R1 R2
      bcdec_pkg::ST_RAMALL, bcdec_pkg::ST_STACK: d.st = bcdec_pkg::ST_DECODE;
      bcdec_pkg::ST_DECODE:
      begin
        if (opt_key_ok)
        begin
          d.mp_mode = cfg_opt[bcdec_pkg::MST_LSB +: 2]; // R14
          d.errpin = cfg_opt[bcdec_pkg::ERRPIN_LSB +: 2]; // R16
          d.node = cfg_opt[bcdec_pkg::NODE_LSB +: 4]; // R17
        end
        else
        begin
          d.mp_mode = bcdec_pkg::MST_OFF; // R13
          d.errpin = bcdec_pkg::ERRPIN_OFF;
        end
        d.mp_run = q.full && d.mp_mode != bcdec_pkg::MST_OFF;
        if (ent[33] && !ent[32] && !emu_key_bad)
        begin
          d.entry = ent[31:0];
          d.st = bcdec_pkg::ST_MST;
        end
        else if (q.dbg)
          d.st = bcdec_pkg::ST_WAIT; // R23 R24
        else
        begin
          d.entry = bcdec_pkg::FLASH_ENTRY[0]; // R23
          d.st = ent[32] ? bcdec_pkg::ST_WAIT : bcdec_pkg::ST_MST;
        end
      end
      bcdec_pkg::ST_MST:
        d.st = (ent[32] && q.entry == 32'h0) ? bcdec_pkg::ST_WAIT : bcdec_pkg::ST_DONE;
      bcdec_pkg::ST_DONE: d.st = bcdec_pkg::ST_RUN; // R25
      bcdec_pkg::ST_RUN: d.st = bcdec_pkg::ST_RUN;
      bcdec_pkg::ST_WAIT: d.st = bcdec_pkg::ST_WAIT; // R21
      bcdec_pkg::ST_ERRINIT: d.st = bcdec_pkg::ST_RESET;
      bcdec_pkg::ST_RESET: d.st = bcdec_pkg::ST_RESET;
      default: d.st = bcdec_pkg::ST_IDLE;
    endcase
    // a wait-mode byte chosen in decode must not reach the done strobe
    if (q.st == bcdec_pkg::ST_DECODE && ent[32] && ent[33] && !q.dbg)
      d.st = bcdec_pkg::ST_WAIT; // R21
    // exceptions override the step in progress, worst first
    if (active)
    begin
      if (ram_uncorrectable || rom_parity_error)
        d.st = bcdec_pkg::ST_ERRINIT; // R6
      else if (flash_uncorrectable || selftest_nmi)
        d.st = bcdec_pkg::ST_RESET; // R7
      else if (illegal_instruction_trap)
      begin
        d.trap = trap_address; // R8
        d.st = bcdec_pkg::ST_RESET;
      end
      else if (clock_fail || trace_analysis_nmi || config_logic_nmi)
        d.nmi_clr = 1'b1; // R5
    end
    // write channel: address and data taken in either order
    if (awvalid && awready)
    begin
      d.aw_ok = 1'b1;
      d.aw_idx = awaddr[21:2];
    end
    if (wvalid && wready)
    begin
      d.w_ok = 1'b1;
      d.wd = wdata;
      d.ws = wstrb;
    end
    if (q.aw_ok && q.w_ok)
    begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bv = 1'b1;
      d.br = bcdec_pkg::RESP_OKAY;
      case (q.aw_idx)
        bcdec_pkg::IDX_EMU_PIN: d.emu[0] = bcdec_merge(q.emu[0], q.wd, q.ws); // R12
        bcdec_pkg::IDX_EMU_OPT: d.emu[1] = bcdec_merge(q.emu[1], q.wd, q.ws);
        bcdec_pkg::IDX_EMU_TLO: d.emu[2] = bcdec_merge(q.emu[2], q.wd, q.ws);
        bcdec_pkg::IDX_EMU_THI: d.emu[3] = bcdec_merge(q.emu[3], q.wd, q.ws);
        bcdec_pkg::IDX_Z1_PIN, bcdec_pkg::IDX_Z1_OPT, bcdec_pkg::IDX_Z1_TLO,
        bcdec_pkg::IDX_Z1_THI:
          if (q.prog1[q.aw_idx[2:1]])
            d.br = bcdec_pkg::RESP_SLVERR; // R12
          else
          begin
            d.z1[q.aw_idx[2:1]] = bcdec_merge(q.z1[q.aw_idx[2:1]], q.wd, q.ws);
            d.prog1[q.aw_idx[2:1]] = 1'b1;
          end
        bcdec_pkg::IDX_Z2_PIN, bcdec_pkg::IDX_Z2_OPT, bcdec_pkg::IDX_Z2_TLO,
        bcdec_pkg::IDX_Z2_THI:
          if (q.prog2[q.aw_idx[2:1]])
            d.br = bcdec_pkg::RESP_SLVERR; // R12
          else
          begin
            d.z2[q.aw_idx[2:1]] = bcdec_merge(q.z2[q.aw_idx[2:1]], q.wd, q.ws);
            d.prog2[q.aw_idx[2:1]] = 1'b1;
          end
        // write one to clear; an event in the same cycle stays set
        bcdec_pkg::IDX_LOG:
          d.log = (q.log & ~q.wd[bcdec_pkg::LOG_W-1:0]) | log_set;
        bcdec_pkg::IDX_STATUS, bcdec_pkg::IDX_ENTRY, bcdec_pkg::IDX_TRAP:
          d.br = bcdec_pkg::RESP_OKAY;
        default: d.br = bcdec_pkg::RESP_DECERR;
      endcase
    end
    if (q.bv && bready)
      d.bv = 1'b0;
    // read channel: one cycle from address to data
    if (q.rv && rready)
      d.rv = 1'b0;
    if (arvalid && arready)
    begin
      d.rv = 1'b1;
      d.rr = bcdec_pkg::RESP_OKAY;
      d.rd = 32'h0;
      case (araddr[21:2])
        bcdec_pkg::IDX_EMU_PIN: d.rd = q.emu[0];
        bcdec_pkg::IDX_EMU_OPT: d.rd = q.emu[1];
        bcdec_pkg::IDX_EMU_TLO: d.rd = q.emu[2];
        bcdec_pkg::IDX_EMU_THI: d.rd = q.emu[3];
        bcdec_pkg::IDX_Z1_PIN: d.rd = q.z1[0];
        bcdec_pkg::IDX_Z1_OPT: d.rd = q.z1[1];
        bcdec_pkg::IDX_Z1_TLO: d.rd = q.z1[2];
        bcdec_pkg::IDX_Z1_THI: d.rd = q.z1[3];
        bcdec_pkg::IDX_Z2_PIN: d.rd = q.z2[0];
        bcdec_pkg::IDX_Z2_OPT: d.rd = q.z2[1];
        bcdec_pkg::IDX_Z2_TLO: d.rd = q.z2[2];
        bcdec_pkg::IDX_Z2_THI: d.rd = q.z2[3];
        bcdec_pkg::IDX_STATUS:
          d.rd = {q.prog2, q.prog1, 16'h0000, q.wiped, q.dbg, q.ext, q.full,
                  4'(q.st)};
        bcdec_pkg::IDX_ENTRY: d.rd = q.entry;
        bcdec_pkg::IDX_LOG: d.rd = {25'h0, q.log};
        bcdec_pkg::IDX_TRAP: d.rd = q.trap;
        default: d.rr = bcdec_pkg::RESP_DECERR;
      endcase
    end
  end

  // single state register; zone words and flags are otp, so they survive reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.z1 <= q.z1; // R12
      q.z2 <= q.z2;
      q.prog1 <= q.prog1;
      q.prog2 <= q.prog2;
      q.st <= bcdec_pkg::ST_IDLE;
      q.emu <= {4{bcdec_pkg::CFG_RESET}};
      q.mp_mode <= bcdec_pkg::MST_OFF;
      q.errpin <= bcdec_pkg::ERRPIN_OFF;
    end
    else
      q <= d;
  end

  // handshakes and outputs
  assign awready = !q.aw_ok && !q.bv;
  assign wready = !q.w_ok && !q.bv;
  assign bvalid = q.bv;
  assign bresp = q.br;
  assign arready = !q.rv;
  assign rvalid = q.rv;
  assign rdata = q.rd;
  assign rresp = q.rr;
  assign clk_div_cfg = q.st == bcdec_pkg::ST_CLKDIV;
  assign flash_power_up = q.st == bcdec_pkg::ST_FLASHUP;
  assign trim_apply = q.st == bcdec_pkg::ST_TRIM;
  assign ram_init_all = q.st inside {bcdec_pkg::ST_RAMALL, bcdec_pkg::ST_ERRINIT};
  assign stack_clear = q.st == bcdec_pkg::ST_STACK;
  assign nmi_flag_clear = q.nmi_clr;
  assign device_reset_req = q.st == bcdec_pkg::ST_RESET;
  assign memory_selftest_start = q.st == bcdec_pkg::ST_MST && q.mp_run && !mp_skip;
  assign memory_selftest_mode = q.mp_mode;
  assign error_status_output_sel = q.errpin;
  assign error_status_mux = (q.errpin == bcdec_pkg::ERRPIN_OFF) ? 4'h0 : bcdec_pkg::ERRPIN_MUX;
  assign error_status_locked = q.errpin != bcdec_pkg::ERRPIN_OFF; // R16
  assign scan_node_identifier = q.node;
  assign entry_address = q.entry;
  assign boot_done = q.st == bcdec_pkg::ST_DONE; // R25
  assign wait_loop = q.st == bcdec_pkg::ST_WAIT;
  assign debug_halt_point = wait_loop && q.dbg; // R21

  // checks
  sequence s_power_steps;
    clk_div_cfg ##1 flash_power_up ##1 trim_apply;
  endsequence
  sequence s_err_reset;
    ram_init_all ##1 device_reset_req [*2];
  endsequence
  property p_full_init;
    @(posedge aclk) disable iff (!aresetn)
    (q.st == bcdec_pkg::ST_IDLE && (por_reset || brownout_reset) && !active)
    |=> s_power_steps ##1 ram_init_all;
  endproperty
  a_full_init: assert property (p_full_init) else $error("power reset sequence"); // R1
  property p_ext_init;
    @(posedge aclk) disable iff (!aresetn)
    (q.st == bcdec_pkg::ST_IDLE && external_pin_reset && !por_reset && !brownout_reset)
    |=> s_power_steps ##1 stack_clear;
  endproperty
  a_ext_init: assert property (p_ext_init) else $error("external reset sequence"); // R2
  property p_short_init;
    @(posedge aclk) disable iff (!aresetn)
    (q.st == bcdec_pkg::ST_IDLE && !por_reset && !brownout_reset &&
     !external_pin_reset && !nmi_watchdog_reset) |=> stack_clear && !clk_div_cfg;
  endproperty
  a_short_init: assert property (p_short_init) else $error("short reset sequence"); // R3
  property p_ram_err;
    @(posedge aclk) disable iff (!aresetn)
    (active && (ram_uncorrectable || rom_parity_error)) |=> s_err_reset;
  endproperty
  a_ram_err: assert property (p_ram_err) else $error("ram error handling"); // R6
  property p_flash_err;
    @(posedge aclk) disable iff (!aresetn)
    (active && flash_uncorrectable && !ram_uncorrectable && !rom_parity_error)
    |=> device_reset_req && q.log[bcdec_pkg::LOG_FLASH];
  endproperty
  a_flash_err: assert property (p_flash_err) else $error("flash error handling"); // R7
  property p_trap;
    @(posedge aclk) disable iff (!aresetn)
    (active && illegal_instruction_trap && !ram_uncorrectable && !rom_parity_error &&
     !flash_uncorrectable && !selftest_nmi)
    |=> q.trap == $past(trap_address) && device_reset_req;
  endproperty
  a_trap: assert property (p_trap) else $error("trap address not kept"); // R8
  property p_nmi_continue;
    @(posedge aclk) disable iff (!aresetn)
    (active && clock_fail && !ram_uncorrectable && !rom_parity_error &&
     !flash_uncorrectable && !selftest_nmi && !illegal_instruction_trap)
    |=> nmi_flag_clear && !device_reset_req && q.log[bcdec_pkg::LOG_CLK];
  endproperty
  a_nmi_continue: assert property (p_nmi_continue) else $error("nmi not cleared"); // R5
  property p_key;
    @(posedge aclk) disable iff (!aresetn)
    (q.st == bcdec_pkg::ST_DECODE && !opt_key_ok)
    |=> error_status_output_sel == bcdec_pkg::ERRPIN_OFF && !memory_selftest_start;
  endproperty
  a_key: assert property (p_key) else $error("options used without key"); // R13
  property p_wait;
    @(posedge aclk) disable iff (!aresetn)
    wait_loop |=> wait_loop && !boot_done;
  endproperty
  a_wait: assert property (p_wait) else $error("wait loop left"); // R21
endmodule
`default_nettype wire

// file: include/bcdec_pkg.sv
// boot configuration decoder: register map, field layout, codes and states
package bcdec_pkg;
  // register indices; byte address is four times the index
  localparam logic [19:0] IDX_EMU_PIN = 20'h00d00;
  localparam logic [19:0] IDX_EMU_OPT = 20'h00d02;
  localparam logic [19:0] IDX_EMU_TLO = 20'h00d04;
  localparam logic [19:0] IDX_EMU_THI = 20'h00d06;
  localparam logic [19:0] IDX_Z1_PIN = 20'h5f008;
  localparam logic [19:0] IDX_Z1_OPT = 20'h5f00a;
  localparam logic [19:0] IDX_Z1_TLO = 20'h5f00c;
  localparam logic [19:0] IDX_Z1_THI = 20'h5f00e;
  localparam logic [19:0] IDX_Z2_PIN = 20'h5f088;
  localparam logic [19:0] IDX_Z2_OPT = 20'h5f08a;
  localparam logic [19:0] IDX_Z2_TLO = 20'h5f08c;
  localparam logic [19:0] IDX_Z2_THI = 20'h5f08e;
  localparam logic [19:0] IDX_STATUS = 20'h00e00;
  localparam logic [19:0] IDX_ENTRY = 20'h00e02;
  localparam logic [19:0] IDX_LOG = 20'h00e04;
  localparam logic [19:0] IDX_TRAP = 20'h00e06;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // key and option fields
  localparam int KEY_LSB = 24;
  localparam int MST_LSB = 6;
  localparam int ERRPIN_LSB = 4;
  localparam int NODE_LSB = 0;
  localparam logic [7:0] KEY_VALID = 8'h5a;
  localparam logic [7:0] KEY_ALT = 8'ha5;
  localparam logic [1:0] MST_OSC = 2'h0;
  localparam logic [1:0] MST_OFF = 2'h3;
  localparam logic [1:0] ERRPIN_OFF = 2'h3;
  localparam logic [3:0] ERRPIN_MUX = 4'hd;
  localparam logic [7:0] FACTORY_BYTE = 8'h03;
  // boot modes in the low nibble of a table byte
  localparam logic [3:0] MODE_FLASH = 4'h3;
  localparam logic [3:0] MODE_WAIT = 4'h4;
  localparam logic [3:0] MODE_RAM = 4'h5;
  localparam logic [3:0] MODE_SECURE = 4'ha;
  localparam logic [5:0][31:0] FLASH_ENTRY = {32'h0009_fff0, 32'h0009_8000,
    32'h0009_0000, 32'h0008_fff0, 32'h0008_8000, 32'h0008_0000};
  localparam logic [31:0] RAM_ENTRY = 32'h0000_0000;
  localparam int FLASH_OPTS = 6;
  localparam int SECURE_OPTS = 5;
  // event log bits
  localparam int LOG_CLK = 0;
  localparam int LOG_RAM = 1;
  localparam int LOG_ROM = 2;
  localparam int LOG_FLASH = 3;
  localparam int LOG_TRACE = 4;
  localparam int LOG_CFGL = 5;
  localparam int LOG_TRAP = 6;
  localparam int LOG_W = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [3:0] {ST_IDLE, ST_CLKDIV, ST_FLASHUP, ST_TRIM, ST_RAMALL,
    ST_STACK, ST_DECODE, ST_MST, ST_DONE, ST_RUN, ST_WAIT, ST_ERRINIT,
    ST_RESET} bcdec_st_t;
endpackage

// file: verif/bcdec_cpu_model.sv
// cpu fetch logic and debugger probe facing the boot sequencer
`timescale 1ns/1ps
`default_nettype none
module bcdec_cpu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic plug,
  output logic debugger_attached,
  input wire logic boot_done,
  input wire logic [31:0] entry_address,
  input wire logic debug_halt_point,
  output logic [31:0] fetch_addr,
  output logic [7:0] fetch_cnt,
  output logic halted
);
  // probe presence simply follows the cable
  assign debugger_attached = plug;
  // count strobes so a doubled or missing boot end shows up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fetch_cnt <= 8'h00;
      halted <= 1'b0;
    end
    else
    begin
      if (boot_done)
      begin
        fetch_addr <= entry_address;
        fetch_cnt <= fetch_cnt + 8'h01;
      end
      if (debug_halt_point)
        halted <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verif/bcdec_top_tb.sv
// self-checking bench: reset causes, boot exceptions and register access
`timescale 1ns/1ps
`default_nettype none
module bcdec_top_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, plug, debugger_attached, pll_locked, ram_erased;
  logic clk_div_cfg, flash_power_up, trim_apply, ram_init_all, stack_clear, nmi_flag_clear;
  logic device_reset_req, memory_selftest_start, error_status_locked, boot_done;
  logic wait_loop, debug_halt_point, halted, hard, full;
  logic [1:0] bresp, rresp, memory_selftest_mode, error_status_output_sel, r;
  logic [2:0] idx;
  logic [3:0] wstrb, error_status_mux, scan_node_identifier;
  logic [6:0] cause;
  logic [7:0] obs, fetch_cnt;
  logic [8:0] ev;
  logic [31:0] awaddr, wdata, araddr, rdata, entry_address, trap_address, fetch_addr, d, q;
  int failures, total_checks, cyc, i, k;
  int seed = 32'hc2d0;
  int at [8];
  // step pulses in order, then the exception responses
  assign obs = {device_reset_req, nmi_flag_clear, boot_done, stack_clear, ram_init_all,
    trim_apply, flash_power_up, clk_div_cfg};
  bcdec_top bcdec_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .por_reset(cause[0]), .brownout_reset(cause[1]),
    .external_pin_reset(cause[2]), .nmi_watchdog_reset(cause[3]),
    .secure_copy_reset(cause[4]), .simulated_cpu_reset(cause[5]), .debugger_reset(cause[6]),
    .debugger_attached, .boot_pin_index(idx), .pll_locked, .ram_erased, .clock_fail(ev[0]),
    .ram_uncorrectable(ev[1]), .rom_parity_error(ev[2]), .flash_uncorrectable(ev[3]),
    .trace_analysis_nmi(ev[4]), .config_logic_nmi(ev[5]), .illegal_instruction_trap(ev[6]),
    .selftest_nmi(ev[7]), .unsupported_irq(ev[8]), .trap_address, .clk_div_cfg,
    .flash_power_up, .trim_apply, .ram_init_all, .stack_clear, .nmi_flag_clear,
    .device_reset_req, .memory_selftest_start, .memory_selftest_mode,
    .error_status_output_sel, .error_status_mux, .error_status_locked, .scan_node_identifier,
    .entry_address, .boot_done, .wait_loop, .debug_halt_point);
  bcdec_cpu_model bcdec_cpu_model_inst (.aclk, .aresetn, .plug, .debugger_attached,
    .boot_done, .entry_address, .debug_halt_point, .fetch_addr, .fetch_cnt, .halted);
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // cut a hang short, far beyond the longest expected run
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      conclude();
    end
  end
  // write with both halves offered together; bready held until the answer
  task automatic wr(input logic [19:0] i, input logic [31:0] v, output logic [1:0] s);
    @(posedge aclk);
    awaddr <= {10'h000, i, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    s = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] i, output logic [31:0] v, output logic [1:0] s);
    @(posedge aclk);
    araddr <= {10'h000, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    v = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask
  // reset with a cause, then log the first cycle of each pulse; event in stack step
  task automatic boot(input logic [6:0] c, input logic p, input logic [8:0] e);
    int t;
    aresetn <= 1'b0;
    cause <= c;
    plug <= p;
    idx <= 3'($random(seed));
    ram_erased <= 1'($random(seed));
    pll_locked <= 1'($random(seed));
    trap_address <= $random(seed);
    for (k = 0; k < 8; k++)
      at[k] = -1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (t = 0; t < 16; t++)
    begin
      @(posedge aclk);
      ev <= (at[0] >= 0 && t == at[0] + 3) ? e : 9'h000;
      #1;
      for (k = 0; k < 8; k++)
        if (obs[k] && at[k] < 0)
          at[k] = t;
    end
  endtask
  initial
  begin
    {cause, ev, plug, idx, ram_erased, trap_address, awaddr, wdata, araddr} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    pll_locked = 1'b1;
    // each reset cause standalone, blank words give factory flash boot
    for (i = 0; i < 7; i++)
    begin
      boot(7'(1 << i), 1'b0, 9'h000);
      full = i < 2;
      chk(at[0] < 0, i >= 4);
      chk(at[1], i < 4 ? at[0] + 1 : -1);
      chk(at[2], i < 4 ? at[0] + 2 : -1);
      chk(at[3], full ? at[0] + 3 : -1);
      chk(at[4], full ? -1 : at[5] - 3);
      chk(at[5], i < 4 ? at[0] + 6 : at[4] + 3);
      chk(fetch_cnt, 8'h01);
      chk(fetch_addr, 32'h0008_0000);
      chk({error_status_output_sel, memory_selftest_mode}, 4'hf);
      rd(bcdec_pkg::IDX_STATUS, d, r);
      chk(d[7], i == 3 && ram_erased);
    end
    // debugger present with blank emulation words parks in wait
    boot(7'h01, 1'b1, 9'h000);
    chk(wait_loop, 1'b1);
    chk(debug_halt_point, 1'b1);
    chk(halted, 1'b1);
    chk(fetch_cnt, 8'h00);
    // one exception per boot, injected during the stack clear step
    for (i = 0; i < 9; i++)
    begin
      boot(7'h04, 1'b0, 9'(1 << i));
      hard = i inside {[1:3], 6, 7};
      chk(at[7], hard ? at[0] + (i < 3 ? 5 : 4) : -1);
      chk(at[3], (i == 1 || i == 2) ? at[0] + 4 : -1);
      chk(at[6], i inside {0, 4, 5} ? at[0] + 4 : -1);
      chk(fetch_cnt, !hard);
      rd(bcdec_pkg::IDX_LOG, d, r);
      chk(d, i < 7 ? 1 << i : 0);
      if (i == 6)
      begin
        rd(bcdec_pkg::IDX_TRAP, d, r);
        chk(d, trap_address);
      end
    end
    // emulation words rewrite freely, zone words take one write only
    d = {8'h5a, 24'($random(seed))};
    wr(bcdec_pkg::IDX_EMU_OPT, d, r);
    wr(bcdec_pkg::IDX_EMU_OPT, ~d, r);
    chk(r, bcdec_pkg::RESP_OKAY);
    rd(bcdec_pkg::IDX_EMU_OPT, q, r);
    chk(q, ~d);
    wr(bcdec_pkg::IDX_Z2_PIN, 32'h5a00_0000, r);
    wr(bcdec_pkg::IDX_Z2_OPT, d, r);
    chk(r, bcdec_pkg::RESP_OKAY);
    wr(bcdec_pkg::IDX_Z2_OPT, ~d, r);
    chk(r, bcdec_pkg::RESP_SLVERR);
    rd(bcdec_pkg::IDX_Z2_OPT, q, r);
    chk(q, d);
    wr(20'h00100, d, r);
    chk(r, bcdec_pkg::RESP_DECERR);
    rd(20'h00100, q, r);
    chk(r, bcdec_pkg::RESP_DECERR);
    // valid zone 2 keys steer a standalone boot
    boot(7'h01, 1'b0, 9'h000);
    chk(fetch_addr, 32'h0008_0000);
    chk({memory_selftest_mode, error_status_output_sel, scan_node_identifier},
      d[7:0]);
    chk({error_status_locked, error_status_mux}, d[5:4] == 2'h3 ? 5'h00 : 5'h1d);
    conclude();
  end
endmodule
`default_nettype wire
